// ---- core/pwmflt_pkg.sv ----
`default_nettype none
package pwmflt_pkg;
  localparam int NGEN = 4;
  localparam int NFLT = 4;
  localparam int NIRQ = 6;
  localparam int PER_W = 16;
  // Register map; generator block g sits at GEN_BASE + g * GEN_STRIDE
  localparam logic [11:0] OFS_SENSE = 12'h000;
  localparam logic [11:0] OFS_MOD_ISR = 12'h004;
  localparam logic [11:0] OFS_MOD_IMR = 12'h008;
  localparam logic [11:0] OFS_MOD_MIS = 12'h00C;
  localparam logic [11:0] GEN_BASE = 12'h040;
  localparam logic [11:0] GEN_STRIDE = 12'h040;
  localparam logic [5:0] OFS_G_MODE = 6'h00;
  localparam logic [5:0] OFS_G_FSEL = 6'h04;
  localparam logic [5:0] OFS_G_MINPER = 6'h08;
  localparam logic [5:0] OFS_G_FSTAT = 6'h0C;
  localparam logic [5:0] OFS_G_FCLR = 6'h10;
  localparam logic [5:0] OFS_G_RIS = 6'h14;
  localparam logic [5:0] OFS_G_IEN = 6'h18;
  localparam logic [5:0] OFS_G_MIS = 6'h1C;
  // Mode bit positions
  localparam int MODE_LATCH_BIT = 0;
  localparam int MODE_MINPER_BIT = 1;
  localparam int MODE_EXTSEL_BIT = 2;
  localparam logic [3:0] FSEL_RESET = 4'h1;
  localparam logic [3:0] SENSE_RESET = 4'hF;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  typedef struct packed {
    logic ext_sel;
    logic min_per;
    logic latch;
  } pwmflt_mode_s;
  typedef struct packed {
    logic [5:0] word;
    logic [1:0] blk;
    logic gen;
  } pwmflt_addr_s;
endpackage
`default_nettype wire

// ---- core/pwmflt_top.sv ----
// Behaviour
// R1: Software clears chosen latched triggers per generator
// R2: Min period counts clocks, only when enabled
// R3: Hold fault at least programmed cycle count
// R4: Per-input programmable polarity for four inputs
// R5: Status live when unlatched, latched otherwise
// R6: Status bit one means trigger active
// R7: Latched trigger stays until software clears
// R8: Selection mask readable back per generator
// R9: Input zero only unless extended select
// R10: Software programs mask when extended select
// R11: Fault is OR of sense-corrected selected inputs
// R12: Write one clears generator interrupt status
// R13: Single fault group zero of four inputs
// R14: Module fault interrupt from generator fault
// R15: Fault interrupt held during minimum period
// R16: Generator status readable raw and masked
// R17: Generators independent in mask, latch, counter
`default_nettype none
module pwmflt_top #(
  parameter int PER_W = pwmflt_pkg::PER_W
) (
  input wire logic clk_i,                        // Modulation clock
  input wire logic rst_b_i,                      // Sync reset, active low
  input wire logic [3:0] fault_i,                // External fault inputs
  input wire logic [23:0] gen_evt_i,             // Generator events, 6 per generator
  input wire logic hsel_i,                       // AHB select
  input wire logic [11:0] haddr_i,               // AHB address
  input wire logic [1:0] htrans_i,               // AHB transfer type
  input wire logic hwrite_i,                     // AHB write
  input wire logic [2:0] hsize_i,                // AHB size
  input wire logic [31:0] hwdata_i,              // AHB write data
  input wire logic hready_i,                     // AHB ready in
  output logic [31:0] hrdata_o,                  // AHB read data
  output logic hreadyout_o,                      // AHB ready out
  output logic hresp_o,                          // AHB response
  output logic [3:0] gen_fault_o,                // Per-generator fault
  output logic [3:0] gen_irq_o,                  // Per-generator interrupt
  output logic fault_irq_o                       // Module fault interrupt
);
  localparam int NG = pwmflt_pkg::NGEN;
  localparam int NI = pwmflt_pkg::NIRQ;

  // Bus address phase capture
  logic wr_pend_r, wr_pend_nxt, rd_pend_r, rd_pend_nxt;
  logic [11:0] addr_r, addr_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic take;
  assign take = hsel_i && hready_i && (htrans_i == pwmflt_pkg::HTRANS_NONSEQ)
                && (hsize_i == pwmflt_pkg::HSIZE_WORD);
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign hrdata_o = rdata_r;

  // Register state
  logic [3:0] sense_r, sense_nxt;
  logic [3:0] mod_isr_r, mod_isr_nxt, mod_imr_r, mod_imr_nxt;
  pwmflt_pkg::pwmflt_mode_s mode_r [NG];
  pwmflt_pkg::pwmflt_mode_s mode_nxt [NG];
  logic [3:0] fsel_r [NG];
  logic [3:0] fsel_nxt [NG];
  logic [PER_W-1:0] minper_r [NG];
  logic [PER_W-1:0] minper_nxt [NG];
  logic [3:0] latch_r [NG];
  logic [3:0] latch_nxt [NG];
  logic [PER_W-1:0] cnt_r [NG];
  logic [PER_W-1:0] cnt_nxt [NG];
  logic [NI-1:0] ris_r [NG];
  logic [NI-1:0] ris_nxt [NG];
  logic [NI-1:0] ien_r [NG];
  logic [NI-1:0] ien_nxt [NG];
  logic [3:0] fault_prev_r, fault_prev_nxt;

  // Polarity-corrected inputs
  logic [3:0] act;
  logic [3:0] raw_fault;
  logic [3:0] trig [NG];
  logic [3:0] eff_sel [NG];
  pwmflt_pkg::pwmflt_addr_s wa;
  logic wr_gen;
  logic [1:0] wr_blk;

  // R4: polarity per input
  assign act = ~(fault_i ^ sense_r);
  assign wa = pwmflt_pkg::pwmflt_addr_s'({addr_r[5:0], wr_blk, wr_gen});
  assign wr_gen = (addr_r >= pwmflt_pkg::GEN_BASE)
                  && (addr_r < 12'(pwmflt_pkg::GEN_BASE + NG * pwmflt_pkg::GEN_STRIDE));
  assign wr_blk = 2'((addr_r - pwmflt_pkg::GEN_BASE) >> 6);

  genvar g;
  generate
    for (g = 0; g < NG; g++) begin : gen_g
      // R9: only input zero unless extended select
      assign eff_sel[g] = mode_r[g].ext_sel ? fsel_r[g] : pwmflt_pkg::FSEL_RESET;
      // R13: single group of four inputs
      assign trig[g] = act & eff_sel[g];
      // R11: OR of selected corrected inputs
      assign raw_fault[g] = |trig[g];
      // R3: hold while counter runs
      assign gen_fault_o[g] = raw_fault[g] || (cnt_r[g] != '0);
      assign gen_irq_o[g] = |(ris_r[g] & ien_r[g]);
    end
  endgenerate
  assign fault_irq_o = |(mod_isr_r & mod_imr_r);

  always_comb begin
    logic [31:0] rd;
    logic [5:0] off;
    logic hit;
    rd = 32'h0000_0000;
    off = 6'h00;
    hit = 1'b0;
    wr_pend_nxt = take && hwrite_i;
    rd_pend_nxt = take && !hwrite_i;
    addr_nxt = take ? haddr_i : addr_r;
    sense_nxt = sense_r;
    mod_imr_nxt = mod_imr_r;
    mod_isr_nxt = mod_isr_r;
    fault_prev_nxt = gen_fault_o;
    off = wa.word;
    hit = wa.gen;
    for (int i = 0; i < NG; i++) begin
      mode_nxt[i] = mode_r[i];
      fsel_nxt[i] = fsel_r[i];
      minper_nxt[i] = minper_r[i];
      ien_nxt[i] = ien_r[i];
      latch_nxt[i] = latch_r[i];
      ris_nxt[i] = ris_r[i];
      // R2: counter only when min period enabled
      if (!mode_r[i].min_per) begin
        cnt_nxt[i] = '0;
      // R3: load on assertion, count down
      end else if (raw_fault[i] && !fault_prev_r[i] && cnt_r[i] == '0) begin
        cnt_nxt[i] = minper_r[i];
      end else if (cnt_r[i] != '0) begin
        cnt_nxt[i] = cnt_r[i] - 1'b1;
      end else begin
        cnt_nxt[i] = cnt_r[i];
      end
    end
    // Bus writes
    if (wr_pend_r) begin
      if (!hit) begin
        if (addr_r == pwmflt_pkg::OFS_SENSE) begin
          sense_nxt = hwdata_i[3:0];
        end
        if (addr_r == pwmflt_pkg::OFS_MOD_IMR) begin
          mod_imr_nxt = hwdata_i[3:0];
        end
        if (addr_r == pwmflt_pkg::OFS_MOD_ISR) begin
          mod_isr_nxt = mod_isr_r & ~hwdata_i[3:0];
        end
      end else begin
        unique case (off)
          pwmflt_pkg::OFS_G_MODE: begin
            mode_nxt[wr_blk] = pwmflt_pkg::pwmflt_mode_s'(hwdata_i[2:0]);
          end
          pwmflt_pkg::OFS_G_FSEL: begin
            fsel_nxt[wr_blk] = hwdata_i[3:0];
          end
          pwmflt_pkg::OFS_G_MINPER: begin
            minper_nxt[wr_blk] = hwdata_i[PER_W-1:0];
          end
          // R1: clear chosen latched triggers
          pwmflt_pkg::OFS_G_FCLR: begin
            latch_nxt[wr_blk] = latch_r[wr_blk] & ~hwdata_i[3:0];
          end
          // R12: write one clears
          pwmflt_pkg::OFS_G_RIS: begin
            ris_nxt[wr_blk] = ris_r[wr_blk] & ~hwdata_i[NI-1:0];
          end
          pwmflt_pkg::OFS_G_IEN: begin
            ien_nxt[wr_blk] = hwdata_i[NI-1:0];
          end
          default: begin
          end
        endcase
      end
    end
    // Events set after clears, so a same-cycle event wins
    for (int i = 0; i < NG; i++) begin
      // R7: latch holds until cleared
      // Collects only while latching is on, so enabling it starts clean
      if (mode_r[i].latch) begin
        latch_nxt[i] = latch_nxt[i] | trig[i];
      end else begin
        latch_nxt[i] = 4'h0;
      end
      ris_nxt[i] = ris_nxt[i] | gen_evt_i[i*NI +: NI];
    end
    // R14: R15: module fault status set by generator fault incl. hold, kept until write one clears
    mod_isr_nxt = mod_isr_nxt | gen_fault_o;
    // Reads
    rdata_nxt = rdata_r;
    if (rd_pend_nxt) begin
      off = haddr_i[5:0];
      if (haddr_i >= pwmflt_pkg::GEN_BASE
          && haddr_i < 12'(pwmflt_pkg::GEN_BASE + NG * pwmflt_pkg::GEN_STRIDE)) begin
        unique case (off)
          pwmflt_pkg::OFS_G_MODE: rd = {29'h0, mode_r[2'(haddr_i[7:6] - 2'h1)]};
          // R8: mask readback
          pwmflt_pkg::OFS_G_FSEL: rd = {28'h0, fsel_r[2'(haddr_i[7:6] - 2'h1)]};
          pwmflt_pkg::OFS_G_MINPER: rd = 32'(minper_r[2'(haddr_i[7:6] - 2'h1)]);
          // R5: R6: live or latched, one means active
          pwmflt_pkg::OFS_G_FSTAT: begin
            rd = {28'h0, mode_r[2'(haddr_i[7:6] - 2'h1)].latch
                  ? latch_r[2'(haddr_i[7:6] - 2'h1)] : trig[2'(haddr_i[7:6] - 2'h1)]};
          end
          // R16: raw and masked status
          pwmflt_pkg::OFS_G_RIS: rd = 32'(ris_r[2'(haddr_i[7:6] - 2'h1)]);
          pwmflt_pkg::OFS_G_IEN: rd = 32'(ien_r[2'(haddr_i[7:6] - 2'h1)]);
          pwmflt_pkg::OFS_G_MIS: begin
            rd = 32'(ris_r[2'(haddr_i[7:6] - 2'h1)] & ien_r[2'(haddr_i[7:6] - 2'h1)]);
          end
          default: rd = 32'h0000_0000;
        endcase
      end else begin
        unique case (haddr_i)
          pwmflt_pkg::OFS_SENSE: rd = {28'h0, sense_r};
          pwmflt_pkg::OFS_MOD_ISR: rd = {28'h0, mod_isr_r};
          pwmflt_pkg::OFS_MOD_IMR: rd = {28'h0, mod_imr_r};
          pwmflt_pkg::OFS_MOD_MIS: rd = {28'h0, mod_isr_r & mod_imr_r};
          default: rd = 32'h0000_0000;
        endcase
      end
      rdata_nxt = rd;
    end
  end

  // R17: independent state per generator
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r <= 12'h000;
      rdata_r <= 32'h0000_0000;
      sense_r <= pwmflt_pkg::SENSE_RESET;
      mod_isr_r <= 4'h0;
      mod_imr_r <= 4'h0;
      fault_prev_r <= 4'h0;
      for (int i = 0; i < NG; i++) begin
        mode_r[i] <= '0;
        fsel_r[i] <= pwmflt_pkg::FSEL_RESET;
        minper_r[i] <= '0;
        latch_r[i] <= 4'h0;
        cnt_r[i] <= '0;
        ris_r[i] <= '0;
        ien_r[i] <= '0;
      end
    end else begin
      wr_pend_r <= wr_pend_nxt;
      rd_pend_r <= rd_pend_nxt;
      addr_r <= addr_nxt;
      rdata_r <= rdata_nxt;
      sense_r <= sense_nxt;
      mod_isr_r <= mod_isr_nxt;
      mod_imr_r <= mod_imr_nxt;
      fault_prev_r <= fault_prev_nxt;
      for (int i = 0; i < NG; i++) begin
        mode_r[i] <= mode_nxt[i];
        fsel_r[i] <= fsel_nxt[i];
        minper_r[i] <= minper_nxt[i];
        latch_r[i] <= latch_nxt[i];
        cnt_r[i] <= cnt_nxt[i];
        ris_r[i] <= ris_nxt[i];
        ien_r[i] <= ien_nxt[i];
      end
    end
  end

  // Assertions
  // R9: default source is input zero
  default_src_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R9
    !mode_r[0].ext_sel |-> (raw_fault[0] == act[0])) else $error("gen0 source not input 0");
  // R3: hold after load
  hold_fault_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R3
    (cnt_r[2] > 1 && mode_r[2].min_per) |=> gen_fault_o[2]) else $error("fault not held");
  // R3: fresh fault loads period
  sequence minper_start_s;
    mode_r[2].min_per && raw_fault[2] && !fault_prev_r[2] && cnt_r[2] == '0;
  endsequence
  minper_load_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R3
    minper_start_s |=> cnt_r[2] == $past(minper_r[2])) else $error("period not loaded");
  // R2: no count when disabled
  minper_off_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R2
    !$past(mode_r[2].min_per) |-> cnt_r[2] == '0) else $error("counter ran while disabled");
  // R7: latch persists
  latch_keep_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R7
    (mode_r[1].latch && latch_r[1][0]
     && !(wr_pend_r && wr_gen && addr_r[5:0] == pwmflt_pkg::OFS_G_FCLR))
    |=> latch_r[1][0]) else $error("latched trigger dropped");
  // R5: latch idle while off
  latch_idle_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R5
    !$past(mode_r[1].latch) |-> latch_r[1] == 4'h0) else $error("latch set while off");
  // R12: W1C clears
  isr_clear_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R12
    (wr_pend_r && addr_r == 12'h054 && hwdata_i[0] && !gen_evt_i[0]) |=> !ris_r[0][0])
    else $error("status not cleared");
  // R11: OR of selected
  fault_or_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R11
    (mode_r[3].ext_sel && |(act & fsel_r[3])) |-> gen_fault_o[3]) else $error("OR missing");
  // R15: interrupt during period
  irq_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R15
    (cnt_r[2] != '0) |=> mod_isr_r[2]) else $error("fault irq dropped");
  // R16: irq output gated by enable
  irq_mask_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R16
    (ien_r[0] == '0) |-> !gen_irq_o[0]) else $error("masked irq asserted");
endmodule
`default_nettype wire

// ---- testbench/pwmflt_fault_pins.sv ----
`default_nettype none
module pwmflt_fault_pins (
  input wire logic clk_i,          // Modulation clock
  input wire logic [3:0] level_i,  // Requested pin levels
  output logic [3:0] fault_o       // External fault pins
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pins move only after an edge, like a board-level driver
  always_ff @(posedge clk_i) begin
    fault_o <= level_i;
  end
endmodule
`default_nettype wire

// ---- testbench/testbench.sv ----
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_b = 0, hsel = 0, hwrite = 0, hrdy, hresp, firq;
  logic [11:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = '0;
  logic [31:0] hwdata = '0, hrdata;
  logic [3:0] lvl = '0, flt, gflt, girq;
  logic [23:0] evt = '0;
  int miscompares = 0, compares = 0;
  pwmflt_fault_pins pins (.clk_i(clk), .level_i(lvl), .fault_o(flt));
  pwmflt_top dut (.clk_i(clk), .rst_b_i(rst_b), .fault_i(flt), .gen_evt_i(evt),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
    .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy),
    .hresp_o(hresp), .gen_fault_o(gflt), .gen_irq_o(girq), .fault_irq_o(firq));
  initial forever #50 clk = ~clk;
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic tally_and_finish;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %0t read %h want %h", $time, g, e);
    end
  endtask
  task automatic chk_pin(input logic g, input logic e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %0t pin %b want %b", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= pwmflt_pkg::HTRANS_NONSEQ;
    hsize <= pwmflt_pkg::HSIZE_WORD;
    do @(posedge clk); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk_reg(r, e);
  endtask
  function automatic logic [11:0] ga(input int g, input logic [5:0] o);
    return pwmflt_pkg::GEN_BASE + 12'(g) * pwmflt_pkg::GEN_STRIDE + 12'(o);
  endfunction
  // Sense bit high means the pin counts as asserted when high
  function automatic logic [3:0] trig(input logic [3:0] s, f, sel);
    return ~(f ^ s) & sel;
  endfunction
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    tally_and_finish;
  end
  initial begin
    logic [3:0] s, m, t;
    logic [3:0] sel [4];
    logic [3:0] ext;
    logic [5:0] ien [4];
    logic [5:0] ris, c;
    logic [23:0] ev;
    int n, cnt;
    void'($urandom(46876));
    tick(20);
    rst_b <= 1'b1;
    tick(1);
    rd_chk(pwmflt_pkg::OFS_SENSE, 32'hF);
    rd_chk(12'h200, 32'h0);
    chk_pin(hresp, 1'b0);
    for (int g = 0; g < 4; g++) rd_chk(ga(g, pwmflt_pkg::OFS_G_FSEL), 32'h1);
    repeat (30) begin
      s = 4'($urandom);
      wr(pwmflt_pkg::OFS_SENSE, {28'h0, s});
      ext = 4'($urandom);
      for (int g = 0; g < 4; g++) begin
        sel[g] = 4'($urandom);
        wr(ga(g, pwmflt_pkg::OFS_G_MODE), {29'h0, ext[g], 2'b00});
        wr(ga(g, pwmflt_pkg::OFS_G_FSEL), {28'h0, sel[g]});
      end
      lvl <= 4'($urandom);
      tick(2);
      for (int g = 0; g < 4; g++) begin
        t = trig(s, lvl, ext[g] ? sel[g] : 4'h1);
        chk_pin(gflt[g], |t);
        rd_chk(ga(g, pwmflt_pkg::OFS_G_FSTAT), {28'h0, t});
        rd_chk(ga(g, pwmflt_pkg::OFS_G_FSEL), {28'h0, sel[g]});
      end
    end
    lvl <= 4'h0;
    wr(pwmflt_pkg::OFS_SENSE, 32'hF);
    wr(ga(1, pwmflt_pkg::OFS_G_MODE), 32'h5);
    wr(ga(1, pwmflt_pkg::OFS_G_FSEL), 32'hF);
    lvl <= 4'hB;
    tick(3);
    lvl <= 4'h0;
    tick(3);
    rd_chk(ga(1, pwmflt_pkg::OFS_G_FSTAT), 32'hB);
    wr(ga(1, pwmflt_pkg::OFS_G_FCLR), 32'h3);
    rd_chk(ga(1, pwmflt_pkg::OFS_G_FSTAT), 32'h8);
    n = 3 + $urandom_range(0, 7);
    wr(ga(2, pwmflt_pkg::OFS_G_MINPER), n);
    for (int k = 0; k < 2; k++) begin
      wr(ga(2, pwmflt_pkg::OFS_G_MODE), k ? 32'h2 : 32'h0);
      lvl <= 4'h1;
      tick(1);
      lvl <= 4'h0;
      cnt = 0;
      repeat (30) begin
        tick(1);
        cnt += (gflt[2] === 1'b1);
      end
      chk_pin(k ? (cnt >= n && cnt <= n + 2) : (cnt == 1), 1'b1);
    end
    for (int g = 0; g < 4; g++) begin
      ien[g] = 6'($urandom);
      wr(ga(g, pwmflt_pkg::OFS_G_IEN), {26'h0, ien[g]});
    end
    ev = 24'($urandom);
    evt <= ev;
    tick(1);
    evt <= 24'h0;
    tick(1);
    for (int g = 0; g < 4; g++) begin
      ris = ev[g*6 +: 6];
      c = 6'($urandom);
      rd_chk(ga(g, pwmflt_pkg::OFS_G_RIS), {26'h0, ris});
      rd_chk(ga(g, pwmflt_pkg::OFS_G_MIS), {26'h0, ris & ien[g]});
      chk_pin(girq[g], |(ris & ien[g]));
      wr(ga(g, pwmflt_pkg::OFS_G_RIS), {26'h0, c});
      rd_chk(ga(g, pwmflt_pkg::OFS_G_RIS), {26'h0, ris & ~c});
    end
    for (int g = 0; g < 4; g++) wr(ga(g, pwmflt_pkg::OFS_G_MODE), 32'h0);
    tick(20);
    wr(pwmflt_pkg::OFS_MOD_ISR, 32'hF);
    rd_chk(pwmflt_pkg::OFS_MOD_ISR, 32'h0);
    m = 4'($urandom);
    wr(pwmflt_pkg::OFS_MOD_IMR, {28'h0, m});
    lvl <= 4'h1;
    tick(2);
    lvl <= 4'h0;
    tick(2);
    rd_chk(pwmflt_pkg::OFS_MOD_ISR, 32'hF);
    rd_chk(pwmflt_pkg::OFS_MOD_MIS, {28'h0, m});
    chk_pin(firq, |m);
    wr(pwmflt_pkg::OFS_MOD_ISR, 32'h5);
    rd_chk(pwmflt_pkg::OFS_MOD_ISR, 32'hA);
    tally_and_finish;
  end
endmodule
`default_nettype wire
